/* lsb_pkg.sv */
// Constants shared by the load/store lane, interlock and branch-target block
// Operation
// (R1) Integer address is base plus signed immediate
// (R2) Float accesses allow base-immediate or register-indexed
// (R3) Load-use hazard stalls until data valid
// (R4) Address names low-order byte, per endianness
// (R5) Lanes from size and low three bits
// (R6) Illegal size/alignment raises address error
// (R7) Fetches halfword or word, same byte ordering
// (R8) Multiply runs apart, writes result high/low
// (R9) Reading result registers early stalls pipeline
// (R10) Delay slot executes after branches, except an untaken likely branch (R14)
// (R11) Jump target: PC top four, field shifted
// (R12) Register jump takes full register address
// (R13) Branch target: slot address plus shifted offset
// (R14) Untaken likely branch nullifies delay slot
// (R15) Software keeps control transfers out of slots
// (R16) Computation takes register or immediate operand
// (R17) Trap instructions decoded only in register form
package lsb_pkg;
	localparam logic [5:0] OP_SPECIAL = 6'h00;
	localparam logic [5:0] OP_REGIMM = 6'h01;
	localparam logic [5:0] OP_J = 6'h02;
	localparam logic [5:0] OP_JAL = 6'h03;
	localparam logic [5:0] OP_BEQ = 6'h04;
	localparam logic [5:0] OP_BGTZ = 6'h07;
	localparam logic [5:0] OP_ADDI = 6'h08;
	localparam logic [5:0] OP_LUI = 6'h0f;
	localparam logic [5:0] OP_BEQL = 6'h14;
	localparam logic [5:0] OP_BGTZL = 6'h17;
	localparam logic [5:0] OP_COP1X = 6'h13;
	localparam logic [5:0] FN_JR = 6'h08;
	localparam logic [5:0] FN_JALR = 6'h09;
	localparam logic [5:0] FN_MOVE_FROM_RESULT_HIGH = 6'h10;
	localparam logic [5:0] FN_MOVE_FROM_RESULT_LOW = 6'h12;
	localparam logic [5:0] FN_MULT = 6'h18;
	localparam logic [5:0] FN_MULTU = 6'h19;
	localparam logic [2:0] FN_TRAP_HI = 3'h6;
	localparam logic [2:0] FN_SYS_HI = 3'h1;
	localparam logic [2:0] FN_SYS_LO_MSB = 3'h4;
	localparam logic [1:0] RI_TRAP = 2'h1;
	localparam logic [1:0] RI_BR_LIKELY = 2'h1;
	// Access sizes
	localparam logic [2:0] SZ_BYTE = 3'h0;
	localparam logic [2:0] SZ_HALF = 3'h1;
	localparam logic [2:0] SZ_TRIPLE = 3'h2;
	localparam logic [2:0] SZ_WORD = 3'h3;
	localparam logic [2:0] SZ_DOUBLE = 3'h4;
	// Multiplier latency in cycles
	localparam logic [2:0] MUL_LAT = 3'h4;
	typedef enum logic [1:0] {
		LSB_MUL_IDLE = 2'b00,
		LSB_MUL_BUSY = 2'b01,
		LSB_MUL_DONE = 2'b11
	} lsb_mul_st_t;
endpackage

/* lsb_lane_decode.sv */
// Byte-lane selection and alignment check for one access
`timescale 1ns/1ps
`default_nettype none
module lsb_lane_decode (
	input wire logic [2:0] size_i,
	input wire logic [2:0] addr_i,
	input wire logic big_endian_i,
	output logic [7:0] lanes_o,
	output logic addr_err_o
);
	logic [3:0] nbytes;
	logic legal;
	logic [7:0] mask_le;
	logic [15:0] shifted;
	// ------------------------------------------------------------
	// Alignment
	// ------------------------------------------------------------
	// (R5) size and low bits
	assign legal = (size_i == lsb_pkg::SZ_BYTE) ? 1'b1 :
		(size_i == lsb_pkg::SZ_HALF) ? ~addr_i[0] :
		(size_i == lsb_pkg::SZ_TRIPLE) ? ~addr_i[1] :
		(size_i == lsb_pkg::SZ_WORD) ? (addr_i[1:0] == 2'h0) :
		(size_i == lsb_pkg::SZ_DOUBLE) ? (addr_i == 3'h0) : 1'b0;
	// (R6) error instead of access
	assign addr_err_o = ~legal;
	assign nbytes = (size_i == lsb_pkg::SZ_DOUBLE) ? 4'h8 : {1'b0, size_i} + 4'h1;
	assign mask_le = 8'hff >> (4'h8 - nbytes);
	assign shifted = {8'h00, mask_le} << addr_i;
	// ------------------------------------------------------------
	// Lanes
	// ------------------------------------------------------------
	// (R4) big endian mirrors lane numbering
	assign lanes_o = !legal ? 8'h00 :
		big_endian_i ? {<<{shifted[7:0]}} : shifted[7:0];
endmodule
`default_nettype wire

/* lsb_multiplier.sv */
// Multiplier running beside the pipeline with result high/low registers
`timescale 1ns/1ps
`default_nettype none
module lsb_multiplier (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic start_i,
	input wire logic signed_i,
	input wire logic [31:0] a_i,
	input wire logic [31:0] b_i,
	output logic busy_o,
	output logic [31:0] result_high_reg_o,
	output logic [31:0] result_low_reg_o
);
	lsb_pkg::lsb_mul_st_t state;
	lsb_pkg::lsb_mul_st_t next_state;
	logic [2:0] cnt;
	logic [63:0] prod;
	logic [63:0] next_prod;
	// Operands widened first so the signed product keeps its upper half
	assign next_prod = signed_i ? $signed({{32{a_i[31]}}, a_i}) * $signed({{32{b_i[31]}}, b_i}) :
		{32'h0, a_i} * {32'h0, b_i};
	always_comb begin
		case (state)
			lsb_pkg::LSB_MUL_IDLE: next_state = start_i ? lsb_pkg::LSB_MUL_BUSY : state;
			lsb_pkg::LSB_MUL_BUSY: next_state = (cnt == 3'h1) ? lsb_pkg::LSB_MUL_DONE : state;
			lsb_pkg::LSB_MUL_DONE: next_state = start_i ? lsb_pkg::LSB_MUL_BUSY : lsb_pkg::LSB_MUL_IDLE;
			default: next_state = lsb_pkg::LSB_MUL_IDLE;
		endcase
	end
	// (R8) product lands in result registers
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= lsb_pkg::LSB_MUL_IDLE;
			cnt <= 3'h0;
			prod <= 64'h0;
		end else begin
			state <= next_state;
			if (start_i && state != lsb_pkg::LSB_MUL_BUSY) begin
				cnt <= lsb_pkg::MUL_LAT - 3'h1;
				prod <= next_prod;
			end else if (cnt != 3'h0) begin
				cnt <= cnt - 3'h1;
			end
		end
	end
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			result_high_reg_o <= 32'h0;
			result_low_reg_o <= 32'h0;
		end else if (state == lsb_pkg::LSB_MUL_BUSY && cnt == 3'h1) begin
			result_high_reg_o <= prod[63:32];
			result_low_reg_o <= prod[31:0];
		end
	end
	assign busy_o = (state == lsb_pkg::LSB_MUL_BUSY);
endmodule
`default_nettype wire

/* lsb_exec.sv */
// Execute-stage address, lane, interlock and branch-target logic
`timescale 1ns/1ps
`default_nettype none
module lsb_exec (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic instr_valid_i,
	input wire logic [31:0] instr_i,
	input wire logic [31:0] pc_i,
	input wire logic [31:0] rs_val_i,
	input wire logic [31:0] rt_val_i,
	input wire logic mem_req_i,
	input wire logic mem_write_i,
	input wire logic [2:0] mem_size_i,
	input wire logic fp_indexed_i,
	input wire logic load_i,
	input wire logic big_endian_i,
	input wire logic compressed_mode_i,
	input wire logic load_data_valid_i,
	input wire logic br_cond_i,
	output logic [31:0] mem_addr_o,
	output logic [7:0] mem_lanes_o,
	output logic mem_req_o,
	output logic mem_we_o,
	output logic addr_err_o,
	output logic [7:0] fetch_lanes_o,
	output logic stall_o,
	output logic redirect_o,
	output logic [31:0] target_o,
	output logic nullify_slot_o,
	output logic operand_imm_o,
	output logic [31:0] operand_b_o,
	output logic trap_instr_o,
	output logic [31:0] result_high_reg_o,
	output logic [31:0] result_low_reg_o
);
	// ------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------
	logic [5:0] op;
	logic [5:0] fn;
	logic [4:0] rs;
	logic [4:0] rt;
	logic [4:0] rt_field;
	logic [15:0] imm;
	logic [31:0] simm;
	logic is_special;
	logic is_regimm;
	logic is_jfmt;
	logic is_jreg;
	logic is_branch;
	logic is_likely;
	logic is_mult;
	logic reads_hilo;
	assign op = instr_i[31:26];
	assign rs = instr_i[25:21];
	assign rt = instr_i[20:16];
	assign rt_field = instr_i[20:16];
	assign fn = instr_i[5:0];
	assign imm = instr_i[15:0];
	assign simm = {{16{imm[15]}}, imm};
	assign is_special = (op == lsb_pkg::OP_SPECIAL);
	assign is_regimm = (op == lsb_pkg::OP_REGIMM);
	assign is_jfmt = (op == lsb_pkg::OP_J) || (op == lsb_pkg::OP_JAL);
	assign is_jreg = is_special && ((fn == lsb_pkg::FN_JR) || (fn == lsb_pkg::FN_JALR));
	assign is_likely = ((op >= lsb_pkg::OP_BEQL) && (op <= lsb_pkg::OP_BGTZL)) ||
		(is_regimm && rt_field[1] && (rt_field[4:3] != lsb_pkg::RI_TRAP));
	assign is_branch = ((op >= lsb_pkg::OP_BEQ) && (op <= lsb_pkg::OP_BGTZ)) ||
		((op >= lsb_pkg::OP_BEQL) && (op <= lsb_pkg::OP_BGTZL)) ||
		(is_regimm && (rt_field[4:3] != lsb_pkg::RI_TRAP) && (rt_field[2] == 1'b0));
	assign is_mult = is_special && ((fn == lsb_pkg::FN_MULT) || (fn == lsb_pkg::FN_MULTU));
	assign reads_hilo = is_special && ((fn == lsb_pkg::FN_MOVE_FROM_RESULT_HIGH) || (fn == lsb_pkg::FN_MOVE_FROM_RESULT_LOW));
	// ------------------------------------------------------------
	// Operand and trap decode
	// ------------------------------------------------------------
	// (R16) immediate form for the ALU-immediate opcodes
	assign operand_imm_o = (op >= lsb_pkg::OP_ADDI) && (op <= lsb_pkg::OP_LUI);
	assign operand_b_o = operand_imm_o ? simm : rt_val_i;
	// (R17) traps only in register form; immediate traps are not accepted
	assign trap_instr_o = instr_valid_i && is_special &&
		((fn[5:3] == lsb_pkg::FN_TRAP_HI) ||
		((fn[5:3] == lsb_pkg::FN_SYS_HI) && (fn[2:1] == lsb_pkg::FN_SYS_LO_MSB[2:1])));
	// ------------------------------------------------------------
	// Address formation
	// ------------------------------------------------------------
	logic [31:0] next_addr;
	logic lane_err;
	logic [7:0] lanes;
	logic [7:0] fetch_lanes;
	logic fetch_err;
	// (R1) base plus signed immediate; (R2) float may use register index
	assign next_addr = fp_indexed_i ? rs_val_i + rt_val_i : rs_val_i + simm;
	// (R5) lanes from size and low bits
	lsb_lane_decode u_data_lanes (
		.size_i(mem_size_i),
		.addr_i(next_addr[2:0]),
		.big_endian_i(big_endian_i),
		.lanes_o(lanes),
		.addr_err_o(lane_err)
	);
	// (R7) fetch size follows code mode, same ordering
	lsb_lane_decode u_fetch_lanes (
		.size_i(compressed_mode_i ? lsb_pkg::SZ_HALF : lsb_pkg::SZ_WORD),
		.addr_i(pc_i[2:0]),
		.big_endian_i(big_endian_i),
		.lanes_o(fetch_lanes),
		.addr_err_o(fetch_err)
	);
	logic access_go;
	assign access_go = instr_valid_i && mem_req_i && !stall_o;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mem_addr_o <= 32'h0;
			mem_lanes_o <= 8'h00;
			mem_req_o <= 1'b0;
			mem_we_o <= 1'b0;
			addr_err_o <= 1'b0;
			fetch_lanes_o <= 8'h00;
		end else begin
			mem_addr_o <= next_addr;
			mem_lanes_o <= lanes;
			// (R6) a misaligned access is dropped and flagged
			mem_req_o <= access_go && !lane_err;
			mem_we_o <= access_go && !lane_err && mem_write_i;
			addr_err_o <= (access_go && lane_err) || fetch_err;
			fetch_lanes_o <= fetch_lanes;
		end
	end
	// ------------------------------------------------------------
	// Interlocks
	// ------------------------------------------------------------
	logic load_pend;
	logic [4:0] load_dest;
	logic load_use;
	logic mul_busy;
	// (R3) consumer of a pending load waits for its data
	assign load_use = load_pend && !load_data_valid_i && (load_dest != 5'h0) &&
		((rs == load_dest) || (rt == load_dest));
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			load_pend <= 1'b0;
			load_dest <= 5'h0;
		end else if (access_go && load_i && !lane_err) begin
			load_pend <= 1'b1;
			load_dest <= rt;
		end else if (load_data_valid_i) begin
			load_pend <= 1'b0;
		end
	end
	// (R8) multiplier works while the pipeline moves on
	lsb_multiplier u_mul (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.start_i(instr_valid_i && is_mult && !stall_o),
		.signed_i(fn == lsb_pkg::FN_MULT),
		.a_i(rs_val_i),
		.b_i(rt_val_i),
		.busy_o(mul_busy),
		.result_high_reg_o(result_high_reg_o),
		.result_low_reg_o(result_low_reg_o)
	);
	// (R9) early read of result registers stalls; second multiply also waits
	assign stall_o = instr_valid_i && (load_use || (mul_busy && (reads_hilo || is_mult)));
	// ------------------------------------------------------------
	// Branch and jump targets
	// ------------------------------------------------------------
	logic [31:0] slot_pc;
	logic [31:0] next_target;
	logic take;
	logic is_xfer;
	assign slot_pc = pc_i + 32'h4;
	// (R11) (R12) (R13) target selection
	assign next_target = is_jfmt ? {pc_i[31:28], instr_i[25:0], 2'b00} :
		is_jreg ? rs_val_i :
		slot_pc + {simm[29:0], 2'b00};
	assign is_xfer = is_jfmt || is_jreg || is_branch;
	assign take = is_jfmt || is_jreg || (is_branch && br_cond_i);
	// (R10) redirect after the slot; a taken transfer leaves the slot unsquashed
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			redirect_o <= 1'b0;
			target_o <= 32'h0;
			nullify_slot_o <= 1'b0;
		end else begin
			redirect_o <= instr_valid_i && !stall_o && is_xfer && take;
			target_o <= next_target;
			// (R14) untaken likely branch kills the slot
			nullify_slot_o <= instr_valid_i && !stall_o && is_likely && !br_cond_i;
		end
	end
endmodule
`default_nettype wire

/* lsb_exec_asserts.sv */
// Concurrent checks on the exec block ports
`timescale 1ns/1ps
`default_nettype none
module lsb_exec_asserts (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic instr_valid_i,
	input wire logic [31:0] instr_i,
	input wire logic [31:0] pc_i,
	input wire logic [31:0] rs_val_i,
	input wire logic [31:0] rt_val_i,
	input wire logic mem_req_i,
	input wire logic [2:0] mem_size_i,
	input wire logic fp_indexed_i,
	input wire logic big_endian_i,
	input wire logic br_cond_i,
	input wire logic stall_o,
	input wire logic [31:0] mem_addr_o,
	input wire logic [7:0] mem_lanes_o,
	input wire logic mem_req_o,
	input wire logic addr_err_o,
	input wire logic redirect_o,
	input wire logic [31:0] target_o,
	input wire logic nullify_slot_o,
	input wire logic [31:0] result_high_reg_o,
	input wire logic [31:0] result_low_reg_o
);
	wire tk = instr_valid_i && !stall_o;
	wire [5:0] op = instr_i[31:26];
	wire [31:0] simm = {{16{instr_i[15]}}, instr_i[15:0]};
	wire [31:0] ea = rs_val_i + simm;
	wire [31:0] bt = pc_i + 32'h4 + {simm[29:0], 2'b00};
	wire [31:0] jt = {pc_i[31:28], instr_i[25:0], 2'b00};
	wire [63:0] prod = {32'h0, rs_val_i} * {32'h0, rt_val_i};
	wire dm = tk && mem_req_i && !fp_indexed_i;
	wire sp = op == lsb_pkg::OP_SPECIAL;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	sequence s_mul; tk && sp && instr_i[5:0] == lsb_pkg::FN_MULTU; endsequence
	sequence s_lik; tk && op >= lsb_pkg::OP_BEQL && op <= lsb_pkg::OP_BGTZL && !br_cond_i; endsequence
	property p_addr; dm |=> mem_addr_o == $past(ea); endproperty
	a_addr: assert property (p_addr) else $error("bad address");
	property p_word; dm && mem_size_i == lsb_pkg::SZ_WORD && ea[2:0] == 3'h4 && !big_endian_i
		|=> mem_req_o && mem_lanes_o == 8'hf0; endproperty
	a_word: assert property (p_word) else $error("bad word lanes");
	property p_err; dm && mem_size_i == lsb_pkg::SZ_HALF && ea[0] |=> addr_err_o && !mem_req_o;
	endproperty
	a_err: assert property (p_err) else $error("odd halfword accepted");
	property p_br; tk && op == lsb_pkg::OP_BEQ && br_cond_i |=> redirect_o && target_o == $past(bt);
	endproperty
	a_br: assert property (p_br) else $error("bad branch target");
	property p_j; tk && op == lsb_pkg::OP_J |=> redirect_o && target_o == $past(jt); endproperty
	a_j: assert property (p_j) else $error("bad jump target");
	property p_jr; tk && sp && instr_i[5:0] == lsb_pkg::FN_JR |=> target_o == $past(rs_val_i);
	endproperty
	a_jr: assert property (p_jr) else $error("bad register jump");
	property p_nul; s_lik |=> nullify_slot_o && !redirect_o; endproperty
	a_nul: assert property (p_nul) else $error("slot not nullified");
	property p_mul; s_mul |-> ##4 {result_high_reg_o, result_low_reg_o} == $past(prod, 4); endproperty
	a_mul: assert property (p_mul) else $error("bad product");
endmodule
`default_nettype wire

/* lsb_mem_model.sv */
// Data return path answering each load after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module lsb_mem_model (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [2:0] dly_i,
	output logic data_valid_o
);
	int cnt;
	// A late answer is what forces the dependent instruction to wait
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt <= 0;
			data_valid_o <= 1'b0;
		end else begin
			cnt <= (req_i && !we_i) ? int'(dly_i) : ((cnt > 0) ? cnt - 1 : 0);
			data_valid_o <= cnt == 1;
		end
	end
endmodule
`default_nettype wire

/* lsb_exec_tb.sv */
// Self-checking bench for the exec block
`timescale 1ns/1ps
`default_nettype none
module lsb_exec_tb;
	typedef struct packed {logic [2:0] sz; logic [2:0] a; logic be; logic [7:0] ln; logic er;} lsb_row_t;
	lsb_row_t rows [15] = '{16'h81fe, 16'h9001, 16'h71e0, 16'h721e, 16'h6801, 16'h441c, 16'h560e,
		16'h4801, 16'h2a60, 16'h3980, 16'h2c01, 16'h1e02, 16'h0c10, 16'ha001, 16'h2006};
	logic [7:0] fexp [4] = '{8'hf0, 8'h0f, 8'h0c, 8'h30};
	logic [31:0] ins4 [4] = '{32'h2001ff00, 32'h00221820, 32'h00220034, 32'h04cc0005};
	logic p_we;
	logic clk_i = 1'b0, arst_n_i = 1'b0, instr_valid_i = 1'b0, mem_req_i = 1'b0, mem_write_i = 1'b0;
	logic fp_indexed_i = 1'b0, load_i = 1'b0, big_endian_i = 1'b0, compressed_mode_i = 1'b0;
	logic br_cond_i = 1'b0, load_data_valid_i, mem_req_o, mem_we_o, addr_err_o, stall_o;
	logic redirect_o, nullify_slot_o, operand_imm_o, trap_instr_o, p_rq, p_er, p_rd, p_nl;
	logic [31:0] instr_i = 32'h0, pc_i = 32'h100, rs_val_i = 32'h0, rt_val_i = 32'h0;
	logic [31:0] mem_addr_o, target_o, operand_b_o, result_high_reg_o, result_low_reg_o, p_ad, p_tg;
	logic [2:0] mem_size_i = 3'h0, dly_i = 3'h1;
	logic [7:0] mem_lanes_o, fetch_lanes_o, p_ln, p_fl;
	int n_fail = 0, total_checks = 0, cyc = 0, nst = 0;
	lsb_exec u_lsb_exec (.*);
	lsb_mem_model u_lsb_mem_model (.clk_i, .arst_n_i, .req_i(mem_req_o), .we_i(mem_we_o), .dly_i,
		.data_valid_o(load_data_valid_i));
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cmp_v(input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_b(input logic got, exp);
		cmp_v({31'h0, got}, {31'h0, exp});
	endtask
	// Called at a rising edge; returns at the edge that takes the instruction
	task automatic exec(input logic [31:0] ins, rs, rt, input logic [2:0] sz, md);
		{instr_i, rs_val_i, rt_val_i} <= {ins, rs, rt};
		{mem_size_i, mem_req_i, mem_write_i, load_i, instr_valid_i} <= {sz, md, 1'b1};
		nst = 0;
		@(negedge clk_i);
		{p_ad, p_ln, p_rq, p_er, p_fl, p_rd, p_tg, p_nl} = {mem_addr_o, mem_lanes_o, mem_req_o,
			addr_err_o, fetch_lanes_o, redirect_o, target_o, nullify_slot_o};
		p_we = mem_we_o;
		while (stall_o !== 1'b0 && nst < 40) begin
			nst++;
			@(negedge clk_i);
		end
		@(posedge clk_i);
	endtask
	task automatic nop();
		exec(32'h0, 32'h0, 32'h0, 3'h0, 3'h0);
	endtask
	task automatic ctl(input logic [31:0] pc, ins, rs, input logic c, red, input logic [31:0] tg,
		input logic nul);
		pc_i <= pc;
		br_cond_i <= c;
		exec(ins, rs, 32'h0, 3'h0, 3'h0);
		nop();
		cmp_b(p_rd, red);
		cmp_b(p_nl, nul);
		if (red) cmp_v(p_tg, tg);
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		cmp_b(mem_req_o | redirect_o | addr_err_o, 1'b0);
		cmp_v(result_low_reg_o, 32'h0);
		arst_n_i <= 1'b1;
		@(posedge clk_i);
		// Row fields: size, low address bits, big endian, lanes, error
		foreach (rows[k]) begin
			big_endian_i <= rows[k].be;
			exec(32'hac00fff8, 32'h108 | 32'(rows[k].a), 32'h0, rows[k].sz, 3'b110);
			nop();
			cmp_v({24'h0, p_ln}, {24'h0, rows[k].ln});
			cmp_b(p_er, rows[k].er);
			cmp_b(p_rq, !rows[k].er);
			cmp_b(p_we, !rows[k].er);
			if (!rows[k].er) cmp_v(p_ad, 32'h100 | 32'(rows[k].a));
		end
		for (int k = 0; k < 5; k++) begin
			{compressed_mode_i, big_endian_i} <= 2'(k);
			pc_i <= (k > 1) ? 32'h102 : 32'h104;
			nop();
			nop();
			if (k < 4) cmp_v({24'h0, p_fl}, {24'h0, fexp[k]});
			cmp_b(p_er, k == 4);
		end
		{compressed_mode_i, big_endian_i, fp_indexed_i} <= 3'h1;
		pc_i <= 32'h100;
		exec(32'hac000000, 32'h200, 32'h18, 3'h3, 3'b110);
		fp_indexed_i <= 1'b0;
		nop();
		cmp_v(p_ad, 32'h218);
		// Independent first, so no load is still in flight for the dependent case
		for (int k = 0; k < 2; k++) begin
			dly_i <= k ? 3'h4 : 3'h1;
			exec(32'h8c250000, 32'h100, 32'h0, 3'h3, 3'b101);
			exec(32'h00c71820, 32'h0, 32'h0, 3'h0, 3'h0);
			cmp_b(nst == 0, 1'b1);
			repeat (6) nop();
			exec(32'h8c250000, 32'h100, 32'h0, 3'h3, 3'b101);
			exec(32'h00a21820, 32'h0, 32'h0, 3'h0, 3'h0);
			cmp_b(nst > 0, 1'b1);
		end
		exec(32'h00220019, 32'hffffffff, 32'h2, 3'h0, 3'h0);
		exec(32'h00001810, 32'h0, 32'h0, 3'h0, 3'h0);
		cmp_v(32'(nst), 32'h3);
		nop();
		cmp_v(result_high_reg_o, 32'h1);
		cmp_v(result_low_reg_o, 32'hfffffffe);
		exec(32'h00220018, 32'hffffffff, 32'h2, 3'h0, 3'h0);
		repeat (5) nop();
		cmp_v(result_high_reg_o, 32'hffffffff);
		cmp_v(result_low_reg_o, 32'hfffffffe);
		// slot holds a store, never a transfer
		pc_i <= 32'h1000;
		br_cond_i <= 1'b1;
		exec(32'h1000fffe, 32'h0, 32'h0, 3'h0, 3'h0);
		pc_i <= 32'h1004;
		exec(32'hac000000, 32'h200, 32'h0, 3'h3, 3'b110);
		cmp_v(p_tg, 32'h00000ffc);
		nop();
		cmp_b(p_rq, 1'b1);
		ctl(32'ha0000010, 32'h08123456, 32'h0, 1'b0, 1'b1, 32'ha048d158, 1'b0);
		ctl(32'h2000, 32'h00200008, 32'h80001234, 1'b0, 1'b1, 32'h80001234, 1'b0);
		ctl(32'h2000, 32'h0020f809, 32'h80001234, 1'b0, 1'b1, 32'h80001234, 1'b0);
		ctl(32'h3000, 32'h50000010, 32'h0, 1'b1, 1'b1, 32'h00003044, 1'b0);
		ctl(32'h3000, 32'h04020010, 32'h0, 1'b0, 1'b0, 32'h0, 1'b1);
		for (int k = 0; k < 4; k++) begin
			ctl(32'h3000, {6'h14 + 6'(k), 26'h10}, 32'h0, 1'b0, 1'b0, 32'h0, 1'b1);
		end
		// Immediate and register operand forms, register-only traps
		for (int k = 0; k < 4; k++) begin
			{instr_i, rt_val_i, instr_valid_i} <= {ins4[k], 32'h55, 1'b1};
			@(negedge clk_i);
			cmp_b(operand_imm_o, k == 0);
			cmp_v(operand_b_o, (k != 0) ? 32'h55 : 32'hffffff00);
			cmp_b(trap_instr_o, k == 2);
			@(posedge clk_i);
		end
		wrap_up();
	end
endmodule
bind lsb_exec lsb_exec_asserts u_lsb_exec_asserts (.*);
`default_nettype wire
